// File: include/tqh_pkg.sv
// Constants, register map and types for the trigger qualify/holdoff block
package tqh_pkg;
    ////////////////////////////////////////////////////////////////////////
    localparam int AW = 8;
    localparam int DW = 32;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_COND_A = 8'h04;
    localparam logic [7:0] A_COND_D = 8'h08;
    localparam logic [7:0] A_LEVEL = 8'h0c;
    localparam logic [7:0] A_HYST = 8'h10;
    localparam logic [7:0] A_HO_TIME = 8'h14;
    localparam logic [7:0] A_HO_EV = 8'h18;
    localparam logic [7:0] A_HO_MIN = 8'h1c;
    localparam logic [7:0] A_HO_MAX = 8'h20;
    localparam logic [7:0] A_SCALE = 8'h24;
    localparam logic [7:0] A_FILT = 8'h28;
    localparam logic [7:0] A_CMD = 8'h2c;
    localparam logic [7:0] A_STATUS = 8'h30;
    localparam logic [7:0] A_ELAPSED = 8'h34;
    localparam logic [7:0] A_AUTO_TIME = 8'h38;
    ////////////////////////////////////////////////////////////////////////
    // CTRL fields
    localparam int C_MODE = 0;
    localparam int C_HOLD = 2;
    localparam int C_OR = 5;
    localparam int C_TYPE = 6;
    localparam int C_PDIG = 8;
    localparam int C_CLKSRC = 9;
    localparam int C_SLOPE = 11;
    localparam int C_SRC = 13;
    localparam int C_SEQ = 16;
    localparam int C_FILT = 17;
    localparam int C_HMAN = 19;
    localparam int C_HREL = 20;
    // CMD fields
    localparam int K_FORCE = 0;
    localparam int K_SETA = 1;
    localparam int K_SETD = 2;
    localparam int K_VAL = 3;
    localparam int K_FIND = 5;
    ////////////////////////////////////////////////////////////////////////
    localparam int CLK_MHZ = 40;
    localparam int MS_US = 1000;
    localparam int MS_CYC_DEF = MS_US * CLK_MHZ;
    localparam int FREE_US = 10;
    localparam logic [23:0] FREE_CYC = 24'(FREE_US * CLK_MHZ);
    localparam logic [31:0] ONE_SEC_MS = 32'h0000_03e8;
    localparam int AUTO_TO_SHIFT = 4;
    localparam logic [7:0] AUTO_HYST = 8'h02;
    localparam logic [15:0] LFSR_SEED = 16'hace1;
    localparam logic [15:0] LFSR_TAPS = 16'hb400;
    localparam logic [7:0] HALF_FS = 8'h80;
    localparam logic [1:0] CND_LOW = 2'h1;
    localparam logic [1:0] CND_HIGH = 2'h2;
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {MODE_AUTO, MODE_NORMAL, MODE_FREE} tqh_mode_e;
    typedef enum logic [2:0] {
        HO_OFF, HO_TIME, HO_EVENTS, HO_RANDOM, HO_AUTO
    } tqh_hold_e;
    typedef enum logic [1:0] {TY_EDGE, TY_STATE, TY_PATTERN} tqh_type_e;
    typedef enum logic [1:0] {SL_RISE, SL_FALL, SL_EITHER} tqh_slope_e;
    typedef enum logic [2:0] {
        SRC_CH0, SRC_CH1, SRC_CH2, SRC_CH3, SRC_LINE, SRC_EXT, SRC_SERIAL
    } tqh_src_e;
    typedef enum logic [1:0] {
        FLT_OFF, FLT_LOW_FREQ_REJECT, FLT_HIGH_FREQ_REJECT
    } tqh_filt_e;
endpackage

// File: hw/tqh_trigger.sv
// Trigger qualification, mode pacing, holdoff, hysteresis and filter
`timescale 1ns/1ps
module tqh_trigger #(
    parameter int MS_CYC = tqh_pkg::MS_CYC_DEF
) (
    input wire logic SYS_CLK_IN,
    input wire logic NRST_IN,
    input wire logic [7:0] ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [31:0] RDATA_OUT,
    input wire logic [31:0] ANA_CH_IN,
    input wire logic [7:0] DIG_CH_IN,
    input wire logic MAINS_IN,
    input wire logic EXT_TRIG_IN,
    input wire logic SERIAL_TRIG_IN,
    output logic TRIG_OUT,
    output logic NO_TRIG_OUT
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [31:0] ctrl;
        logic [7:0] cond_a;
        logic [15:0] cond_d;
        logic [7:0] level;
        logic [7:0] hyst;
        logic [23:0] ho_time;
        logic [15:0] ho_ev;
        logic [23:0] ho_min;
        logic [23:0] ho_max;
        logic [7:0] ascale;
        logic [15:0] hscale;
        logic [7:0] fcorner;
        logic [15:0] lp;
        logic above;
        logic prev_clk;
        logic prev_pat;
        logic prev_mains;
        logic [23:0] ho_cnt;
        logic [15:0] ev_cnt;
        logic [23:0] to_cnt;
        logic [31:0] ms_div;
        logic [31:0] el_ms;
        logic no_trig;
        logic [15:0] lfsr;
        logic [7:0] pk_max;
        logic [7:0] pk_min;
        logic trig;
        logic [31:0] rdata;
    } tqh_state_s;

    tqh_state_s s;
    tqh_state_s next_s;
    logic acc;
    logic qev;
    logic frc;
    logic he;

    ////////////////////////////////////////////////////////////////////////
    // Don't-care is true under AND and false under OR
    function automatic logic tqh_combine(input logic [7:0] v,
                                         input logic [15:0] c,
                                         input logic [7:0] excl,
                                         input logic use_or);
        logic r;
        logic t;
        r = !use_or;
        for (int i = 0; i < 8; i++) begin
            t = (c[2*i +: 2] == tqh_pkg::CND_HIGH) ? v[i] :
                (c[2*i +: 2] == tqh_pkg::CND_LOW) ? !v[i] : !use_or;
            if (excl[i]) begin
                t = !use_or;
            end
            r = use_or ? (r | t) : (r & t);
        end
        return r;
    endfunction

    function automatic logic [7:0] tqh_sat(input logic [8:0] a,
                                           input logic neg);
        if (a[8]) begin
            return neg ? 8'h00 : 8'hff;
        end
        return a[7:0];
    endfunction

    function automatic logic tqh_edge(input logic prev, input logic cur,
                                      input tqh_pkg::tqh_slope_e sl);
        logic r;
        logic f;
        r = !prev && cur;
        f = prev && !cur;
        return (sl == tqh_pkg::SL_RISE) ? r :
               (sl == tqh_pkg::SL_FALL) ? f : (r | f);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        tqh_pkg::tqh_mode_e mode;
        tqh_pkg::tqh_hold_e hm;
        tqh_pkg::tqh_type_e ty;
        tqh_pkg::tqh_slope_e sl;
        tqh_pkg::tqh_src_e src;
        tqh_pkg::tqh_filt_e fm;
        logic [7:0] x;
        logic [7:0] fx;
        logic [7:0] h;
        logic [7:0] hi_a;
        logic [7:0] clk_s;
        logic [7:0] excl;
        logic [16:0] diff;
        logic [8:0] tmp;
        logic pat;
        logic fire;
        logic busy;
        logic [23:0] tmo;
        logic [23:0] rnd;
        mode = tqh_pkg::tqh_mode_e'(s.ctrl[tqh_pkg::C_MODE +: 2]);
        hm = tqh_pkg::tqh_hold_e'(s.ctrl[tqh_pkg::C_HOLD +: 3]);
        ty = tqh_pkg::tqh_type_e'(s.ctrl[tqh_pkg::C_TYPE +: 2]);
        sl = tqh_pkg::tqh_slope_e'(s.ctrl[tqh_pkg::C_SLOPE +: 2]);
        src = tqh_pkg::tqh_src_e'(s.ctrl[tqh_pkg::C_SRC +: 3]);
        fm = tqh_pkg::tqh_filt_e'(s.ctrl[tqh_pkg::C_FILT +: 2]);
        next_s = s;
        acc = 1'b0;
        qev = 1'b0;
        frc = 1'b0;
        fire = 1'b0;
        pat = 1'b0;
        excl = 8'h00;
        ////////////////////////////////////////////////////////////////////
        // Register writes
        if (WR_IN) begin
            case (ADDR_IN)
                tqh_pkg::A_CTRL: next_s.ctrl = WDATA_IN;
                tqh_pkg::A_COND_A: next_s.cond_a = WDATA_IN[7:0];
                tqh_pkg::A_COND_D: next_s.cond_d = WDATA_IN[15:0];
                tqh_pkg::A_LEVEL: next_s.level = WDATA_IN[7:0];
                tqh_pkg::A_HYST: next_s.hyst = WDATA_IN[7:0];
                tqh_pkg::A_HO_TIME: next_s.ho_time = WDATA_IN[23:0];
                tqh_pkg::A_HO_EV: next_s.ho_ev = WDATA_IN[15:0];
                tqh_pkg::A_HO_MIN: next_s.ho_min = WDATA_IN[23:0];
                tqh_pkg::A_HO_MAX: next_s.ho_max = WDATA_IN[23:0];
                tqh_pkg::A_SCALE: begin
                    next_s.ascale = WDATA_IN[7:0];
                    next_s.hscale = WDATA_IN[23:8];
                end
                tqh_pkg::A_FILT: next_s.fcorner = WDATA_IN[7:0];
                tqh_pkg::A_CMD: begin
                    frc = WDATA_IN[tqh_pkg::K_FORCE];
                    if (WDATA_IN[tqh_pkg::K_SETA]) begin
                        next_s.cond_a = {4{WDATA_IN[tqh_pkg::K_VAL +: 2]}};
                    end
                    if (WDATA_IN[tqh_pkg::K_SETD]) begin
                        next_s.cond_d = {8{WDATA_IN[tqh_pkg::K_VAL +: 2]}};
                    end
                    if (WDATA_IN[tqh_pkg::K_FIND]) begin
                        // Half the span seen since the last request
                        next_s.level = 8'((s.pk_max - s.pk_min) >> 1);
                        next_s.pk_max = 8'h00;
                        next_s.pk_min = 8'hff;
                    end
                end
                default: ;
            endcase
        end
        ////////////////////////////////////////////////////////////////////
        // Trigger path filter on the selected analog channel
        x = ANA_CH_IN[8 * src[1:0] +: 8];
        diff = 17'({x, 8'h00}) - 17'(s.lp);
        next_s.lp = 16'(s.lp + 16'($signed(diff) >>> s.fcorner[3:0]));
        tmp = 9'(x) + 9'(tqh_pkg::HALF_FS);
        tmp = 9'(tmp - 9'(s.lp[15:8]));
        unique case (fm)
            tqh_pkg::FLT_LOW_FREQ_REJECT: fx = tqh_sat(tmp, s.lp[15:8] > x);
            tqh_pkg::FLT_HIGH_FREQ_REJECT: fx = s.lp[15:8];
            default: fx = x;
        endcase
        if (fm == tqh_pkg::FLT_HIGH_FREQ_REJECT) begin
            next_s.lp = 16'(s.lp + 16'($signed(diff) >>> s.fcorner[7:4]));
        end
        if (x > s.pk_max) begin
            next_s.pk_max = x;
        end
        if (x < s.pk_min) begin
            next_s.pk_min = x;
        end
        ////////////////////////////////////////////////////////////////////
        // Hysteresis band: auto fixed, manual absolute or relative
        if (!s.ctrl[tqh_pkg::C_HMAN]) begin
            h = tqh_pkg::AUTO_HYST;
        end else if (s.ctrl[tqh_pkg::C_HREL]) begin
            h = tqh_sat({s.hyst, 1'b0}, 1'b0);
        end else begin
            h = s.hyst;
        end
        if (fx > tqh_sat(9'(s.level) + 9'(h), 1'b0)) begin
            next_s.above = 1'b1;
        end else if (fx < tqh_sat(9'(s.level) - 9'(h), 1'b1)) begin
            next_s.above = 1'b0;
        end
        ////////////////////////////////////////////////////////////////////
        // Qualified event sources
        for (int i = 0; i < 4; i++) begin
            hi_a[i] = ANA_CH_IN[8*i +: 8] >= s.level;
        end
        hi_a[7:4] = 4'h0;
        clk_s = 8'h00;
        clk_s[s.ctrl[tqh_pkg::C_CLKSRC +: 2]] = 1'b1;
        next_s.prev_clk = |(hi_a & clk_s);
        next_s.prev_mains = MAINS_IN;
        if (ty == tqh_pkg::TY_STATE) begin
            excl = clk_s;
        end
        if (s.ctrl[tqh_pkg::C_PDIG]) begin
            pat = tqh_combine(DIG_CH_IN, s.cond_d, excl,
                              s.ctrl[tqh_pkg::C_OR]);
        end else begin
            pat = tqh_combine(hi_a, {8'h00, s.cond_a}, excl,
                              s.ctrl[tqh_pkg::C_OR]);
        end
        next_s.prev_pat = pat;
        unique case (src)
            tqh_pkg::SRC_LINE: qev = tqh_edge(s.prev_mains, MAINS_IN, sl);
            tqh_pkg::SRC_EXT: qev = EXT_TRIG_IN;
            tqh_pkg::SRC_SERIAL: qev = SERIAL_TRIG_IN;
            default: begin
                unique case (ty)
                    tqh_pkg::TY_STATE:
                        qev = pat && tqh_edge(s.prev_clk, next_s.prev_clk, sl);
                    tqh_pkg::TY_PATTERN: qev = pat && !s.prev_pat;
                    default: qev = tqh_edge(s.above, next_s.above, sl);
                endcase
            end
        endcase
        ////////////////////////////////////////////////////////////////////
        // Holdoff; events inside it are dropped, never queued
        he = !(src == tqh_pkg::SRC_EXT || src == tqh_pkg::SRC_SERIAL)
             && !s.ctrl[tqh_pkg::C_SEQ];
        busy = he && s.ho_cnt != 24'h0 && hm != tqh_pkg::HO_EVENTS
               && hm != tqh_pkg::HO_OFF;
        if (s.ho_cnt != 24'h0) begin
            next_s.ho_cnt = s.ho_cnt - 24'h1;
        end
        if (he && hm == tqh_pkg::HO_EVENTS) begin
            if (qev) begin
                if (s.ev_cnt + 16'h1 >= s.ho_ev) begin
                    acc = 1'b1;
                end else begin
                    next_s.ev_cnt = s.ev_cnt + 16'h1;
                end
            end
        end else begin
            acc = qev && !busy;
        end
        ////////////////////////////////////////////////////////////////////
        // Trigger mode pacing
        tmo = 24'(s.hscale) << tqh_pkg::AUTO_TO_SHIFT;
        if (tmo == 24'h0) begin
            tmo = 24'h1;
        end
        unique case (mode)
            tqh_pkg::MODE_FREE:
                fire = s.to_cnt >= tqh_pkg::FREE_CYC - 24'h1;
            tqh_pkg::MODE_AUTO:
                fire = acc || s.to_cnt >= tmo - 24'h1;
            default: fire = acc;
        endcase
        fire = fire || frc;
        if (s.to_cnt != 24'hff_ffff) begin
            next_s.to_cnt = s.to_cnt + 24'h1;
        end
        if (s.ms_div >= 32'(MS_CYC - 1)) begin
            next_s.ms_div = 32'h0;
            if (s.el_ms != 32'hffff_ffff) begin
                next_s.el_ms = s.el_ms + 32'h1;
            end
        end else begin
            next_s.ms_div = s.ms_div + 32'h1;
        end
        rnd = s.ho_min + 24'(s.lfsr);
        if (rnd > s.ho_max) begin
            rnd = s.ho_min;
        end
        next_s.trig = fire;
        if (fire) begin
            next_s.to_cnt = 24'h0;
            next_s.ev_cnt = 16'h0;
            next_s.el_ms = 32'h0;
            next_s.ms_div = 32'h0;
            next_s.lfsr = {s.lfsr[14:0], ^(s.lfsr & tqh_pkg::LFSR_TAPS)};
            unique case (hm)
                tqh_pkg::HO_TIME: next_s.ho_cnt = s.ho_time;
                tqh_pkg::HO_RANDOM: next_s.ho_cnt = rnd;
                tqh_pkg::HO_AUTO:
                    next_s.ho_cnt = 24'(s.ascale * s.hscale);
                default: next_s.ho_cnt = 24'h0;
            endcase
            if (!he) begin
                next_s.ho_cnt = 24'h0;
            end
        end
        next_s.no_trig = mode == tqh_pkg::MODE_NORMAL && !fire
                         && s.el_ms > tqh_pkg::ONE_SEC_MS;
        ////////////////////////////////////////////////////////////////////
        // Register reads, data valid the cycle after the strobe
        next_s.rdata = 32'h0;
        if (RD_IN) begin
            case (ADDR_IN)
                tqh_pkg::A_CTRL: next_s.rdata = s.ctrl;
                tqh_pkg::A_COND_A: next_s.rdata = 32'(s.cond_a);
                tqh_pkg::A_COND_D: next_s.rdata = 32'(s.cond_d);
                tqh_pkg::A_LEVEL: next_s.rdata = 32'(s.level);
                tqh_pkg::A_HYST: next_s.rdata = 32'(s.hyst);
                tqh_pkg::A_HO_TIME: next_s.rdata = 32'(s.ho_time);
                tqh_pkg::A_HO_EV: next_s.rdata = 32'(s.ho_ev);
                tqh_pkg::A_HO_MIN: next_s.rdata = 32'(s.ho_min);
                tqh_pkg::A_HO_MAX: next_s.rdata = 32'(s.ho_max);
                tqh_pkg::A_SCALE: next_s.rdata = 32'({s.hscale, s.ascale});
                tqh_pkg::A_FILT: next_s.rdata = 32'(s.fcorner);
                tqh_pkg::A_STATUS: next_s.rdata = 32'({s.level, h, 6'h0,
                                                       busy, s.no_trig});
                tqh_pkg::A_ELAPSED: next_s.rdata = s.el_ms;
                tqh_pkg::A_AUTO_TIME:
                    next_s.rdata = 32'(s.ascale * s.hscale);
                default: next_s.rdata = 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge SYS_CLK_IN) begin
        if (!NRST_IN) begin
            s <= '0;
            s.ctrl <= 32'h0;
            s.pk_min <= 8'hff;
            s.lfsr <= tqh_pkg::LFSR_SEED;
            s.level <= tqh_pkg::HALF_FS;
        end else begin
            s <= next_s;
        end
    end

    assign RDATA_OUT = s.rdata;
    assign TRIG_OUT = s.trig;
    assign NO_TRIG_OUT = s.no_trig;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_force_fires: assert property (@(posedge SYS_CLK_IN)
        disable iff (!NRST_IN) frc |=> TRIG_OUT)
        else $error("force did not trigger");

    chk_auto_real_wins: assert property (@(posedge SYS_CLK_IN)
        disable iff (!NRST_IN)
        (s.ctrl[1:0] == 2'h0 && acc) |=> (TRIG_OUT && s.to_cnt == 24'h0))
        else $error("real trigger lost in auto mode");

    chk_normal_only: assert property (@(posedge SYS_CLK_IN)
        disable iff (!NRST_IN)
        (s.ctrl[1:0] == 2'h1 && !acc && !frc) |=> !TRIG_OUT)
        else $error("normal mode fired without condition");

    chk_free_ignores: assert property (@(posedge SYS_CLK_IN)
        disable iff (!NRST_IN)
        (s.ctrl[1:0] == 2'h2 && !frc && s.to_cnt == 24'h0)
        |=> !TRIG_OUT [*8])
        else $error("free run fired early");

    chk_notrig_flag: assert property (@(posedge SYS_CLK_IN)
        disable iff (!NRST_IN)
        $rose(NO_TRIG_OUT) |-> $past(s.el_ms) > tqh_pkg::ONE_SEC_MS)
        else $error("no-trigger flag raised too soon");

    chk_hold_block: assert property (@(posedge SYS_CLK_IN)
        disable iff (!NRST_IN)
        (he && s.ctrl[4:2] == 3'h1 && s.ho_cnt > 24'h1 && !frc
         && s.ctrl[1:0] == 2'h1) |=> !TRIG_OUT)
        else $error("trigger taken inside holdoff");

    chk_hold_restart: assert property (@(posedge SYS_CLK_IN)
        disable iff (!NRST_IN)
        (TRIG_OUT && $past(he) && $past(s.ctrl[4:2]) == 3'h1)
        |-> s.ho_cnt == $past(s.ho_time))
        else $error("holdoff not restarted");

    chk_hold_off_ext: assert property (@(posedge SYS_CLK_IN)
        disable iff (!NRST_IN)
        (TRIG_OUT && !$past(he)) |-> s.ho_cnt == 24'h0)
        else $error("holdoff on external source");

    chk_set_all: assert property (@(posedge SYS_CLK_IN)
        disable iff (!NRST_IN)
        (WR_IN && ADDR_IN == tqh_pkg::A_CMD && WDATA_IN[1])
        |=> s.cond_a == {4{$past(WDATA_IN[4:3])}})
        else $error("set-all not applied");
endmodule // tqh_trigger

// File: tb/tqh_probe_model.sv
// Probe front end model feeding analog, digital and mains levels
`timescale 1ns/1ps
module tqh_probe_model (
    input wire logic clk_in,
    input wire logic [31:0] ana_set_in,
    input wire logic [7:0] dig_set_in,
    input wire logic mains_set_in,
    output logic [31:0] ana_out,
    output logic [7:0] dig_out,
    output logic mains_out
);
    // One sample of probe delay, so the bench never sees a zero-lag path
    always_ff @(posedge clk_in) begin
        ana_out <= ana_set_in;
        dig_out <= dig_set_in;
        mains_out <= mains_set_in;
    end
endmodule // tqh_probe_model

// File: tb/tb.sv
// Self-checking bench for the trigger qualify/holdoff block
`timescale 1ns/1ps
module tb;
    localparam int MS = 10;
    logic sys_clk = 0, nrst = 0, wr = 0, rd = 0, ext = 0, mset = 0;
    logic [7:0] addr = 0, dset = 0, dig;
    logic [31:0] wdata = 0, aset = 0, rdata, ana, rnd = 30, v;
    logic mains, trig, no_trig;
    int error_cnt = 0, checks = 0, cyc = 0, ntrig = 0, c0;
    tqh_probe_model i_tqh_probe_model (.clk_in(sys_clk), .ana_set_in(aset),
        .dig_set_in(dset), .mains_set_in(mset), .ana_out(ana),
        .dig_out(dig), .mains_out(mains));
    tqh_trigger #(.MS_CYC(MS)) i_tqh_trigger (.SYS_CLK_IN(sys_clk),
        .NRST_IN(nrst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .ANA_CH_IN(ana), .DIG_CH_IN(dig),
        .MAINS_IN(mains), .EXT_TRIG_IN(ext), .SERIAL_TRIG_IN(1'b0),
        .TRIG_OUT(trig), .NO_TRIG_OUT(no_trig));
    initial forever #12.5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Ceiling sized for roughly three times the planned run
    always @(posedge sys_clk) begin
        cyc++;
        if (trig === 1'b1) ntrig++;
        if (cyc > 40000) begin
            error_cnt++;
            $display("unexpected at %0t: run did not finish", $time);
            close_out();
        end
    end
    task automatic cmp(logic [31:0] got, logic [31:0] exp, string what);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what,
                got, exp);
        end
    endtask
    function automatic logic [31:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction
    function automatic logic [31:0] ctl(int md, int ho, int o, int ty,
                                        int src, int sl);
        return 32'(md | ho << tqh_pkg::C_HOLD | o << tqh_pkg::C_OR
            | ty << tqh_pkg::C_TYPE | 1 << tqh_pkg::C_PDIG
            | sl << tqh_pkg::C_SLOPE | src << tqh_pkg::C_SRC);
    endfunction
    // Don't care channels are neutral: true under AND, false under OR
    function automatic logic pat(logic [15:0] c, logic [7:0] d, logic o);
        logic a;
        logic y;
        logic h;
        a = 1'b1;
        y = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (c[2*i+:2] == tqh_pkg::CND_HIGH
                || c[2*i+:2] == tqh_pkg::CND_LOW) begin
                h = (c[2*i+:2] == tqh_pkg::CND_HIGH) ? d[i] : ~d[i];
                a &= h;
                y |= h;
            end
        end
        return o ? y : a;
    endfunction
    task automatic step(int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wr_reg(logic [7:0] a, logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic ext_pulse();
        @(posedge sys_clk);
        ext <= 1'b1;
        @(posedge sys_clk);
        ext <= 1'b0;
    endtask
    // One full mains period of ten cycles: one rise, one fall
    task automatic mains_pulse();
        @(posedge sys_clk);
        mset <= 1'b1;
        step(5);
        mset <= 1'b0;
        step(4);
    endtask
    task automatic trig_cnt(int n, int exp, string what);
        c0 = ntrig;
        step(n);
        cmp(32'(ntrig - c0), 32'(exp), what);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        step(2);
        nrst <= 1'b1;
        aset <= xs();
        rd_reg(tqh_pkg::A_LEVEL, v);
        cmp(v, 32'h0000_0080, "level reset");
        wr_reg(tqh_pkg::A_SCALE, 32'h0000_0503);
        rd_reg(tqh_pkg::A_AUTO_TIME, v);
        cmp(v, 32'h0000_000f, "auto time");
        c0 = ntrig;
        step(400);
        cmp(32'(ntrig - c0 >= 4 && ntrig - c0 <= 6), 32'h1, "auto");
        wr_reg(tqh_pkg::A_CTRL, ctl(1, 0, 0, 0, 5, 0));
        trig_cnt(200, 0, "normal idle");
        wr_reg(tqh_pkg::A_CMD, 32'h0000_0001);
        trig_cnt(5, 1, "force");
        ext_pulse();
        trig_cnt(3, 1, "ext event");
        wr_reg(tqh_pkg::A_HO_TIME, 32'h0000_0064);
        wr_reg(tqh_pkg::A_CTRL, ctl(1, 1, 0, 0, 5, 0));
        c0 = ntrig;
        ext_pulse();
        step(4);
        ext_pulse();
        step(3);
        cmp(32'(ntrig - c0), 32'h2, "no holdoff on ext");
        wr_reg(tqh_pkg::A_CTRL, ctl(1, 1, 0, 0, 4, 0));
        c0 = ntrig;
        mains_pulse();
        mains_pulse();
        step(110);
        mains_pulse();
        cmp(32'(ntrig - c0), 32'h2, "time holdoff");
        for (int s = 0; s < 3; s++) begin
            wr_reg(tqh_pkg::A_CTRL, ctl(1, 0, 0, 0, 4, s));
            c0 = ntrig;
            repeat (3) mains_pulse();
            cmp(32'(ntrig - c0), (s == 2) ? 32'h6 : 32'h3, "slope");
        end
        wr_reg(tqh_pkg::A_HO_EV, 32'h0000_0003);
        wr_reg(tqh_pkg::A_CTRL, ctl(1, 2, 0, 0, 4, 0));
        c0 = ntrig;
        repeat (6) mains_pulse();
        cmp(32'(ntrig - c0), 32'h2, "event holdoff");
        wr_reg(tqh_pkg::A_CMD, 32'h0000_0014);
        rd_reg(tqh_pkg::A_COND_D, v);
        cmp(v, 32'h0000_aaaa, "set all digital");
        wr_reg(tqh_pkg::A_CMD, 32'h0000_000a);
        rd_reg(tqh_pkg::A_COND_A, v);
        cmp(v, 32'h0000_0055, "set all analog");
        repeat (20) begin
            v = xs();
            v[17:16] = tqh_pkg::CND_HIGH;
            wr_reg(tqh_pkg::A_CTRL, ctl(1, 0, int'(v[31]), 2, 0, 0));
            wr_reg(tqh_pkg::A_COND_D, {16'h0000, v[17:2]});
            for (int i = 0; i < 8; i++)
                dset[i] <= (v[2*i+2+:2] == tqh_pkg::CND_HIGH) ? 1'b0 : 1'b1;
            step(6);
            c0 = ntrig;
            dset <= v[7:0];
            step(6);
            cmp(32'(ntrig != c0), 32'(pat(v[17:2], v[7:0], v[31])),
                "pattern");
        end
        wr_reg(tqh_pkg::A_CTRL, ctl(2, 0, 0, 0, 5, 0));
        step(50);
        c0 = ntrig;
        repeat (3) begin
            ext_pulse();
            step(398);
        end
        cmp(32'(ntrig - c0), 32'h3, "free run");
        wr_reg(tqh_pkg::A_CTRL, ctl(1, 0, 0, 0, 5, 0));
        // Force restarts the elapsed count left over from free run
        wr_reg(tqh_pkg::A_CMD, 32'h0000_0001);
        step(MS * 990);
        cmp(32'(no_trig), 32'h0, "no trigger early");
        step(MS * 20);
        cmp(32'(no_trig), 32'h1, "no trigger late");
        rd_reg(tqh_pkg::A_STATUS, v);
        cmp(32'(v[15:8]), 32'(tqh_pkg::AUTO_HYST), "auto hyst");
        close_out();
    end
endmodule // tb
